// [hw/diff_enc_pkg.sv]
// Constants shared by the differential symbol encoder and its tables
package diff_enc_pkg;

    // Widths of the symbol path
    localparam int STATE_W    = 4;      // Constellation index width
    localparam int MAX_STATES = 16;     // Entries in each table
    localparam int NS_W       = 5;      // Width of the state count
    localparam int CNT_W      = 3;      // Bit counter within a symbol
    localparam int OFF_W      = 5;      // Signed offset width
    localparam int IQ_W       = 16;     // Signed I/Q sample width
    localparam int NUM_DEFS   = 2;      // User I/Q and user FSK tables

    // Selector of the user modulation definition
    localparam logic DEF_IQ  = 1'b0;
    localparam logic DEF_FSK = 1'b1;

    // Values after reset, and the smallest state count
    localparam logic               HIST_RST  = 1'b0;
    localparam logic [STATE_W-1:0] STATE_RST = 4'h0;
    localparam logic [CNT_W-1:0]   CNT_RST   = 3'h0;
    localparam logic [OFF_W-1:0]   OFF_RST   = 5'h00;
    localparam logic [IQ_W-1:0]    IQ_ZERO   = 16'h0000;
    localparam logic [NS_W-1:0]    NS_MIN    = 5'h02;

    // Default four-point map, +1.0 and -1.0 in 2.14 format
    localparam logic [IQ_W-1:0] IQ_POS = 16'h4000;
    localparam logic [IQ_W-1:0] IQ_NEG = 16'hC000;
    localparam int              QPSK_N = 4;
    localparam logic [IQ_W-1:0] QPSK_I [QPSK_N] =
        '{IQ_POS, IQ_NEG, IQ_POS, IQ_NEG};
    localparam logic [IQ_W-1:0] QPSK_Q [QPSK_N] =
        '{IQ_POS, IQ_POS, IQ_NEG, IQ_NEG};

    // Run control, Gray coded
    typedef enum logic [1:0]
    {
        RUN_IDLE   = 2'b00,
        RUN_ACTIVE = 2'b01
    } run_e;

endpackage

// [hw/diff_enc_table.sv]
// Offset tables and constellation map with registered read ports
`timescale 1ns/100ps
module diff_enc_table
(
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    // Offset table write
    input  wire logic                             off_we,
    input  wire logic                             off_def,
    input  wire logic [diff_enc_pkg::STATE_W-1:0] off_waddr,
    input  wire logic [diff_enc_pkg::OFF_W-1:0]   off_wdata,
    // Constellation map write
    input  wire logic                             map_we,
    input  wire logic [diff_enc_pkg::STATE_W-1:0] map_waddr,
    input  wire logic [diff_enc_pkg::IQ_W-1:0]    map_wi,
    input  wire logic [diff_enc_pkg::IQ_W-1:0]    map_wq,
    // Offset read
    input  wire logic                             rd_def,
    input  wire logic [diff_enc_pkg::STATE_W-1:0] off_raddr,
    output logic      [diff_enc_pkg::OFF_W-1:0]   off_rdata,
    // Map read
    input  wire logic [diff_enc_pkg::STATE_W-1:0] map_raddr,
    output logic      [diff_enc_pkg::IQ_W-1:0]    map_ri,
    output logic      [diff_enc_pkg::IQ_W-1:0]    map_rq
);
    import diff_enc_pkg::*;

    logic [OFF_W-1:0] off_q [NUM_DEFS][MAX_STATES];
    logic [OFF_W-1:0] off_d [NUM_DEFS][MAX_STATES];
    logic [IQ_W-1:0]  mi_q  [MAX_STATES];
    logic [IQ_W-1:0]  mi_d  [MAX_STATES];
    logic [IQ_W-1:0]  mq_q  [MAX_STATES];
    logic [IQ_W-1:0]  mq_d  [MAX_STATES];
    logic [OFF_W-1:0] off_rdata_d;
    logic [IQ_W-1:0]  map_ri_d;
    logic [IQ_W-1:0]  map_rq_d;

    // One storage slot per entry, one offset table per definition
    for (genvar e = 0; e < MAX_STATES; e++)
    begin : g_ent
        localparam logic [IQ_W-1:0] I_RST = (e < QPSK_N) ? QPSK_I[e % QPSK_N]
                                                          : IQ_ZERO;
        localparam logic [IQ_W-1:0] Q_RST = (e < QPSK_N) ? QPSK_Q[e % QPSK_N]
                                                          : IQ_ZERO;
        always_comb
        begin
            off_d[0][e] = off_q[0][e];
            off_d[1][e] = off_q[1][e];
            mi_d[e]     = mi_q[e];
            mq_d[e]     = mq_q[e];
            // Constant indices keep each entry owned by its own process
            if (off_we && off_waddr == STATE_W'(e) && off_def == DEF_FSK)
            begin
                off_d[1][e] = off_wdata;
            end
            if (off_we && off_waddr == STATE_W'(e) && off_def == DEF_IQ)
            begin
                off_d[0][e] = off_wdata;
            end
            if (map_we && map_waddr == STATE_W'(e))
            begin
                mi_d[e] = map_wi;
                mq_d[e] = map_wq;
            end
        end
        // Default four-point map loaded at reset
        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
            begin
                off_q[0][e] <= OFF_RST;
                off_q[1][e] <= OFF_RST;
                mi_q[e]     <= I_RST;
                mq_q[e]     <= Q_RST;
            end
            else
            begin
                off_q[0][e] <= off_d[0][e];
                off_q[1][e] <= off_d[1][e];
                mi_q[e]     <= mi_d[e];
                mq_q[e]     <= mq_d[e];
            end
        end
    end

    // Read ports
    always_comb
    begin
        off_rdata_d = off_q[rd_def][off_raddr];
        map_ri_d    = mi_q[map_raddr];
        map_rq_d    = mq_q[map_raddr];
    end

    // Read data leave from registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            off_rdata <= OFF_RST;
            map_ri    <= IQ_ZERO;
            map_rq    <= IQ_ZERO;
        end
        else
        begin
            off_rdata <= off_rdata_d;
            map_ri    <= map_ri_d;
            map_rq    <= map_rq_d;
        end
    end

endmodule

// [hw/differential_symbol_encoder.sv]
// Bit XOR coder, differential state stepper and I/Q output stage
`timescale 1ns/100ps
module differential_symbol_encoder
(
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             sys_rst,
    // Modulation control
    input  wire logic                             mod_start,
    input  wire logic                             mod_stop,
    input  wire logic                             phase_invert,
    input  wire logic                             bit_code_en,
    input  wire logic                             sym_code_en,
    input  wire logic                             playback_src,
    input  wire logic                             mod_def,
    input  wire logic [diff_enc_pkg::NS_W-1:0]    num_states,
    // Raw bit stream
    input  wire logic                             bit_valid,
    input  wire logic                             bit_data,
    // Offset table write
    input  wire logic                             off_we,
    input  wire logic                             off_def,
    input  wire logic [diff_enc_pkg::STATE_W-1:0] off_waddr,
    input  wire logic [diff_enc_pkg::OFF_W-1:0]   off_wdata,
    // Constellation map write
    input  wire logic                             map_we,
    input  wire logic [diff_enc_pkg::STATE_W-1:0] map_waddr,
    input  wire logic [diff_enc_pkg::IQ_W-1:0]    map_wi,
    input  wire logic [diff_enc_pkg::IQ_W-1:0]    map_wq,
    // Mapped output
    output logic                                  iq_valid,
    output logic      [diff_enc_pkg::STATE_W-1:0] state_idx,
    output logic      [diff_enc_pkg::IQ_W-1:0]    i_out,
    output logic      [diff_enc_pkg::IQ_W-1:0]    i_bar,
    output logic      [diff_enc_pkg::IQ_W-1:0]    q_out,
    output logic      [diff_enc_pkg::IQ_W-1:0]    q_bar,
    output logic                                  running
);
    import diff_enc_pkg::*;

    // Smallest b with 2**b not below the state count, at least one and at most STATE_W
    function automatic logic [CNT_W-1:0] bits_for
    (
        input logic [NS_W-1:0] n
    );
        logic [CNT_W-1:0] b;
        b = CNT_W'(STATE_W);
        for (int k = STATE_W - 1; k >= 1; k--)
        begin
            if (int'(n) <= (1 << k))
            begin
                b = CNT_W'(k);
            end
        end
        return b;
    endfunction

    // Fold any signed position into 0 .. n-1
    function automatic logic [STATE_W-1:0] wrap_idx
    (
        input int v,
        input int n
    );
        int t;
        t = v % n;
        if (t < 0)
        begin
            t = t + n;
        end
        return STATE_W'(t);
    endfunction

    // Bit stage state
    run_e               run_q;
    run_e               run_d;
    logic               prev_q;
    logic               prev_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   cnt_d;
    logic [STATE_W-1:0] sr_q;
    logic [STATE_W-1:0] sr_d;
    logic [STATE_W-1:0] sym_q;
    logic [STATE_W-1:0] sym_d;
    logic               sym_vld_q;
    logic               sym_vld_d;
    logic               coded_bit;
    logic [NS_W-1:0]    ns_eff;
    logic [CNT_W-1:0]   bps;

    // State stage
    logic [STATE_W-1:0] st_q;
    logic [STATE_W-1:0] st_d;
    logic               st_vld_q;
    logic               st_vld_d;

    // Output stage
    logic               iq_valid_d;
    logic [IQ_W-1:0]    i_out_d;
    logic [IQ_W-1:0]    i_bar_d;
    logic [IQ_W-1:0]    q_out_d;
    logic [IQ_W-1:0]    q_bar_d;
    logic [IQ_W-1:0]    q_turned;

    // Table read data
    logic [OFF_W-1:0]   off_rdata;
    logic [IQ_W-1:0]    map_ri;
    logic [IQ_W-1:0]    map_rq;

    // Tables live in their own memory
    diff_enc_table u_table
    (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .off_we    (off_we),
        .off_def   (off_def),
        .off_waddr (off_waddr),
        .off_wdata (off_wdata),
        .map_we    (map_we),
        .map_waddr (map_waddr),
        .map_wi    (map_wi),
        .map_wq    (map_wq),
        .rd_def    (mod_def),
        .off_raddr (sym_d),
        .off_rdata (off_rdata),
        .map_raddr (st_d),
        .map_ri    (map_ri),
        .map_rq    (map_rq)
    );

    // State count and symbol width
    always_comb
    begin
        ns_eff = (num_states < NS_MIN) ? NS_MIN : num_states;
        bps    = bits_for(ns_eff);
    end

    // Bit coder and symbol assembly
    always_comb
    begin
        run_d     = run_q;
        prev_d    = prev_q;
        cnt_d     = cnt_q;
        sr_d      = sr_q;
        sym_d     = sym_q;
        sym_vld_d = 1'b0;
        coded_bit = bit_code_en ? (bit_data ^ prev_q) : bit_data;
        unique case (run_q)
            RUN_IDLE:
            begin
                if (mod_start)
                begin
                    run_d = RUN_ACTIVE;
                end
            end
            RUN_ACTIVE:
            begin
                if (mod_stop)
                begin
                    run_d = RUN_IDLE;
                end
                else if (bit_valid)
                begin
                    prev_d = bit_data;
                    // Coded stream replaces raw bits, first bit as MSB
                    sr_d = {sr_q[STATE_W-2:0], coded_bit};
                    if (cnt_q + CNT_W'(1) == bps)
                    begin
                        sym_d     = sr_d;
                        sym_vld_d = 1'b1;
                        sr_d      = STATE_RST;
                        cnt_d     = CNT_RST;
                    end
                    else
                    begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
        endcase
        if (mod_start)
        begin
            prev_d    = HIST_RST;
            cnt_d     = CNT_RST;
            sr_d      = STATE_RST;
            sym_vld_d = 1'b0;
        end
    end

    // Bit stage registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            run_q     <= RUN_IDLE;
            prev_q    <= HIST_RST;
            cnt_q     <= CNT_RST;
            sr_q      <= STATE_RST;
            sym_q     <= STATE_RST;
            sym_vld_q <= 1'b0;
        end
        else
        begin
            run_q     <= run_d;
            prev_q    <= prev_d;
            cnt_q     <= cnt_d;
            sr_q      <= sr_d;
            sym_q     <= sym_d;
            sym_vld_q <= sym_vld_d;
        end
    end

    // Constellation state stepping
    always_comb
    begin
        st_d     = st_q;
        st_vld_d = 1'b0;
        if (sym_vld_q)
        begin
            st_vld_d = 1'b1;
            if (sym_code_en && !playback_src)
            begin
                // Signed step from the table, wrapped at both ends
                st_d = wrap_idx(int'(st_q) + int'($signed(off_rdata)),
                                int'(ns_eff));
            end
            else
            begin
                st_d = wrap_idx(int'(sym_q), int'(ns_eff));
            end
        end
        if (mod_start)
        begin
            st_d     = STATE_RST;
            st_vld_d = 1'b0;
        end
    end

    // State stage registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_q     <= STATE_RST;
            st_vld_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            st_vld_q <= st_vld_d;
        end
    end

    // Mapping and polarity, Q negated when phase_invert is set so the vector turns the other way
    always_comb
    begin
        q_turned   = phase_invert ? (IQ_W'(0) - map_rq) : map_rq;
        iq_valid_d = st_vld_q && !mod_start; // Start drops symbol in flight
        i_out_d    = i_out;
        q_out_d    = q_out;
        i_bar_d    = i_bar;
        q_bar_d    = q_bar;
        if (st_vld_q && !mod_start)
        begin
            i_out_d = map_ri;
            q_out_d = q_turned;
            i_bar_d = IQ_W'(0) - map_ri;
            q_bar_d = IQ_W'(0) - q_turned;
        end
    end

    // Output registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            iq_valid  <= 1'b0;
            state_idx <= STATE_RST;
            i_out     <= IQ_ZERO;
            i_bar     <= IQ_ZERO;
            q_out     <= IQ_ZERO;
            q_bar     <= IQ_ZERO;
            running   <= 1'b0;
        end
        else
        begin
            iq_valid  <= iq_valid_d;
            state_idx <= st_q;
            i_out     <= i_out_d;
            i_bar     <= i_bar_d;
            q_out     <= q_out_d;
            q_bar     <= q_bar_d;
            running   <= (run_d == RUN_ACTIVE);
        end
    end

endmodule

// [bench/bit_source.sv]
// Raw bit source model feeding the encoder one bit per cycle
`timescale 1ns/100ps
module bit_source
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Frame load
    input  wire logic        load,
    input  wire logic [15:0] pat,
    input  wire logic [4:0]  len,
    // Bit stream
    output logic             bit_valid,
    output logic             bit_data,
    output logic             busy
);
    logic [15:0] sr_q;
    logic [4:0]  left_q;
    // Bits still to send
    assign busy = (left_q != 5'h00);
    // First bit first; idle data toggles so stale values never match
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            left_q    <= 5'h00;
            bit_valid <= 1'h0;
            bit_data  <= 1'h0;
        end
        else if (load)
        begin
            left_q    <= len;
            sr_q      <= pat << (5'h10 - len);
            bit_valid <= 1'h0;
        end
        else if (left_q != 5'h00)
        begin
            bit_valid <= 1'h1;
            bit_data  <= sr_q[15];
            sr_q      <= sr_q << 1;
            left_q    <= left_q - 5'h01;
        end
        else
        begin
            bit_valid <= 1'h0;
            bit_data  <= ~bit_data;
        end
    end
endmodule

// [bench/differential_symbol_encoder_properties.sv]
// Concurrent checks on the encoder's ports
`timescale 1ns/100ps
module dse_props
(
    // Clock and reset
    input wire logic                              ref_clk,
    input wire logic                              sys_rst,
    // Control and stream
    input wire logic                              mod_start,
    input wire logic                              mod_stop,
    input wire logic                              bit_valid,
    input wire logic [diff_enc_pkg::NS_W-1:0]     num_states,
    // Outputs
    input wire logic                              iq_valid,
    input wire logic                              running,
    input wire logic [diff_enc_pkg::STATE_W-1:0]  state_idx,
    input wire logic [diff_enc_pkg::IQ_W-1:0]     i_out,
    input wire logic [diff_enc_pkg::IQ_W-1:0]     i_bar,
    input wire logic [diff_enc_pkg::IQ_W-1:0]     q_out,
    input wire logic [diff_enc_pkg::IQ_W-1:0]     q_bar
);
    import diff_enc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Steps of start and idle
    sequence s_start;
        mod_start;
    endsequence
    sequence s_quiet;
        !iq_valid [*3];
    endsequence
    sequence s_idle;
        !running [*6];
    endsequence
    // Output relations
    AST_BAR: assert property (i_bar == -i_out && q_bar == -q_out)
        else $error("complement outputs wrong");
    AST_RESET: assert property ($fell(sys_rst) |->
        state_idx == STATE_RST && !running && i_out == IQ_ZERO)
        else $error("outputs not cleared by reset");
    AST_START: assert property (s_start |=> running ##0 s_quiet)
        else $error("start did not clear the pipeline");
    AST_STOP: assert property (mod_stop && !mod_start |=> !running)
        else $error("stop did not leave run state");
    AST_HOLD: assert property (!iq_valid && !$past(sys_rst) |->
        $stable(i_out) && $stable(q_out))
        else $error("outputs moved without a symbol");
    AST_WRAP: assert property (iq_valid && num_states >= 5'h02 &&
        num_states <= 5'h10 |-> state_idx < num_states)
        else $error("state index out of range");
    AST_IDLE: assert property (s_idle |-> !iq_valid)
        else $error("symbol while idle");
    AST_LAT: assert property (iq_valid |-> $past(bit_valid, 3))
        else $error("symbol without its last bit");
endmodule
bind differential_symbol_encoder dse_props dse_props_inst
(
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mod_start(mod_start),
    .mod_stop(mod_stop), .bit_valid(bit_valid), .num_states(num_states),
    .iq_valid(iq_valid), .running(running), .state_idx(state_idx),
    .i_out(i_out), .i_bar(i_bar), .q_out(q_out), .q_bar(q_bar)
);

// [bench/differential_symbol_encoder_tb.sv]
// Self-checking bench for the differential symbol encoder
`timescale 1ns/100ps
module differential_symbol_encoder_tb;
    import diff_enc_pkg::*;
    typedef struct {logic [3:0] st; logic [15:0] i; logic [15:0] q;} note_s;
    logic        ref_clk = 1'h0, sys_rst = 1'h1, load = 1'h0;
    logic        mod_start = 1'h0, mod_stop = 1'h0, mod_def = 1'h0;
    logic        phase_invert = 1'h0, bit_code_en = 1'h0;
    logic        sym_code_en = 1'h0, playback_src = 1'h0;
    logic        off_we = 1'h0, off_def = 1'h0, map_we = 1'h0;
    logic [4:0]  num_states = 5'h04, len = 5'h00, off_wdata = 5'h00;
    logic [3:0]  off_waddr = 4'h0, map_waddr = 4'h0, state_idx;
    logic [15:0] map_wi = 16'h0000, map_wq = 16'h0000, pat = 16'h0000;
    logic [15:0] i_out, i_bar, q_out, q_bar, mi [16], mq [16];
    logic        bit_valid, bit_data, busy, iq_valid, running;
    logic [31:0] seed = 32'h00000051;
    int          mismatches = 0, cmp_count = 0, w, off_m [2][16];
    note_s       nq [$], e;
    differential_symbol_encoder differential_symbol_encoder_inst
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mod_start(mod_start),
        .mod_stop(mod_stop), .phase_invert(phase_invert),
        .bit_code_en(bit_code_en), .sym_code_en(sym_code_en),
        .playback_src(playback_src), .mod_def(mod_def),
        .num_states(num_states), .bit_valid(bit_valid),
        .bit_data(bit_data), .off_we(off_we), .off_def(off_def),
        .off_waddr(off_waddr), .off_wdata(off_wdata), .map_we(map_we),
        .map_waddr(map_waddr), .map_wi(map_wi), .map_wq(map_wq),
        .iq_valid(iq_valid), .state_idx(state_idx), .i_out(i_out),
        .i_bar(i_bar), .q_out(q_out), .q_bar(q_bar), .running(running)
    );
    bit_source bit_source_inst
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .load(load), .pat(pat),
        .len(len), .bit_valid(bit_valid), .bit_data(bit_data), .busy(busy)
    );
    // Clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Fixed-seed random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Compare helpers
    task automatic chk_st(input logic [3:0] g, input logic [3:0] x);
        cmp_count++;
        if (g !== x)
        begin
            mismatches++;
            $display("MISMATCH %0t state %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_iq(input logic [15:0] g, input logic [15:0] x);
        cmp_count++;
        if (g !== x)
        begin
            mismatches++;
            $display("MISMATCH %0t sample %h expected %h", $time, g, x);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            mismatches++;
            $display("MISMATCH %0t wait ran out", $time);
            results();
        end
    endtask
    // Offset table write, left enabled for back-to-back writes
    task automatic wr_off(input logic d, input logic [3:0] a,
                          input logic [4:0] v);
        @(posedge ref_clk);
        off_we <= 1'h1;
        off_def <= d;
        off_waddr <= a;
        off_wdata <= v;
        off_m[d][a] = int'($signed(v));
    endtask
    // Hand a frame to the source and wait until it is sent
    task automatic send(input logic [15:0] p, input int ln);
        @(posedge ref_clk);
        load <= 1'h1;
        pat <= p;
        len <= 5'(ln);
        @(posedge ref_clk);
        load <= 1'h0;
        #1;
        for (w = 0; w < 40 && busy === 1'h1; w++)
            @(posedge ref_clk) #1;
        tmo(w, 40);
    endtask
    // Predict the symbols of a frame, then start and send it
    task automatic run(input logic [15:0] p, input int ln, input int n,
                       input logic [4:0] f);
        int b, k, sy, cnt, st;
        logic pr, cb;
        note_s x;
        b = 1;
        st = 0;
        sy = 0;
        cnt = 0;
        pr = 1'h0;
        while ((1 << b) < n)
            b++;
        for (k = ln - 1; k >= 0; k--)
        begin
            cb = f[0] ? p[k] ^ pr : p[k];
            pr = p[k];
            sy = sy * 2 + cb;
            cnt++;
            if (cnt == b)
            begin
                st = (f[1] && !f[4]) ?
                    ((st + off_m[f[3]][sy]) % n + n) % n : sy % n;
                x.st = 4'(st);
                x.i = mi[st];
                x.q = f[2] ? -mq[st] : mq[st];
                nq.push_back(x);
                sy = 0;
                cnt = 0;
            end
        end
        @(posedge ref_clk);
        mod_start <= 1'h1;
        num_states <= 5'(n);
        {playback_src, mod_def, phase_invert, sym_code_en, bit_code_en} <= f;
        @(posedge ref_clk);
        mod_start <= 1'h0;
        send(p, ln);
        for (w = 0; w < 20 && nq.size() > 0; w++)
            @(posedge ref_clk);
        tmo(w, 20);
        $display("test %h done", p);
    endtask
    // Output watcher against the oldest note
    always @(posedge ref_clk)
    begin
        if (iq_valid === 1'h1)
        begin
            if (nq.size() == 0)
            begin
                mismatches++;
                $display("MISMATCH %0t unexpected symbol", $time);
            end
            else
            begin
                e = nq.pop_front();
                chk_st(state_idx, e.st);
                chk_iq(i_out, e.i);
                chk_iq(q_out, e.q);
                chk_iq(q_bar, -e.q);
                chk_iq(i_bar, -e.i);
            end
        end
    end
    // Main sequence
    initial
    begin
        for (w = 0; w < 16; w++)
        begin
            mi[w] = (w < QPSK_N) ? QPSK_I[w] : IQ_ZERO;
            mq[w] = (w < QPSK_N) ? QPSK_Q[w] : IQ_ZERO;
            off_m[0][w] = 0;
            off_m[1][w] = 0;
        end
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk) #1;
        chk_st(state_idx, STATE_RST);
        chk_iq(i_out, IQ_ZERO);
        run(16'h001B, 8, 4, 5'h00);
        run(16'h001B, 8, 4, 5'h04);
        run(16'h14CA, 14, 2, 5'h01);
        wr_off(1'h0, 4'h0, 5'h01);
        wr_off(1'h0, 4'h1, 5'h1F);
        wr_off(1'h0, 4'h2, 5'h02);
        wr_off(1'h1, 4'h0, 5'h03);
        wr_off(1'h1, 4'h1, 5'h1E);
        @(posedge ref_clk);
        off_we <= 1'h0;
        run(16'h00E1, 10, 4, 5'h02);
        run(16'h00E1, 10, 4, 5'h0A);
        run(16'h00E1, 10, 4, 5'h12);
        seed = xs(seed);
        @(posedge ref_clk);
        map_we <= 1'h1;
        map_waddr <= 4'h4;
        map_wi <= seed[15:0];
        map_wq <= seed[31:16];
        mi[4] = seed[15:0];
        mq[4] = seed[31:16];
        @(posedge ref_clk);
        map_we <= 1'h0;
        for (int r = 0; r < 3; r++)
        begin
            seed = xs(seed);
            run(seed[15:0], 15, 5, {3'h0, 1'h1, seed[16]});
        end
        @(posedge ref_clk);
        mod_stop <= 1'h1;
        @(posedge ref_clk);
        mod_stop <= 1'h0;
        send(16'hFFFF, 16);
        repeat (6) @(posedge ref_clk);
        chk_st({3'h0, running}, 4'h0);
        chk_st(4'(nq.size()), 4'h0);
        $display("test stop done");
        results();
    end
endmodule
